//--- verilog/vcrcc_consts.svh
`ifndef VCRCC_CONSTS_SVH
`define VCRCC_CONSTS_SVH
// Register byte offsets
`define VCRCC_CAP_OFFSET 12'h110
`define VCRCC_CTL_OFFSET 12'h114
`define VCRCC_ADDR_W 12
// Capability fields
`define VCRCC_ARBCAP_LSB 0
`define VCRCC_ARBCAP_MSB 7
`define VCRCC_ARBCAP_RESET 8'h01
`define VCRCC_ARBCAP_MASK 8'h01
`define VCRCC_APS_BIT 14
`define VCRCC_REJECT_SNOOP_BIT 15
`define VCRCC_MAX_TIME_SLOTS_LSB 16
`define VCRCC_MAX_TIME_SLOTS_MSB 22
`define VCRCC_TBLOFF_LSB 24
`define VCRCC_TBLOFF_MSB 31
`define VCRCC_TBLOFF_RESET 8'h00
// Control fields
`define VCRCC_TCMAP_LSB 0
`define VCRCC_TCMAP_MSB 7
`define VCRCC_TCMAP_RESET 8'hFF
`define VCRCC_TCMAP_WMASK 8'hFE
`define VCRCC_LOAD_BIT 16
`define VCRCC_SEL_LSB 17
`define VCRCC_SEL_MSB 19
`define VCRCC_SEL_RESET 3'h0
`define VCRCC_CHANNEL_IDENTIFIER_LSB 24
`define VCRCC_CHANNEL_IDENTIFIER_MSB 26
`define VCRCC_CHANNEL_IDENTIFIER_VALUE 3'h0
`define VCRCC_CHANNEL_ENABLE_BIT 31
// Cycles the arbitrator takes to latch the table
`define VCRCC_LOAD_CYCLES 4'h4
`endif

//--- verilog/vcrcc_pkg.sv
package vcrcc_pkg;
  typedef logic [31:0] vcrcc_word_t;
  typedef logic [11:0] vcrcc_addr_t;
  typedef enum logic [1:0] {
    VCRCC_LOAD_IDLE,
    VCRCC_LOAD_BUSY
  } vcrcc_load_state_t;
endpackage

//--- verilog/vcrcc_table_loader.sv
`timescale 1ns/1ps
`include "vcrcc_consts.svh"
module vcrcc_table_loader (
  input wire logic clk,
  input wire logic resetn,
  input wire logic load_req,
  input wire logic table_write,
  output logic load_pulse,
  output logic arb_table_status
);
  import vcrcc_pkg::*;
  vcrcc_load_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic stat_reg, stat_next;
  logic pulse_reg, pulse_next;

  ////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    pulse_next = 1'b0;
    stat_next = stat_reg;
    case (state_reg)
      VCRCC_LOAD_IDLE: begin
        if (load_req) begin
          state_next = VCRCC_LOAD_BUSY;
          cnt_next = `VCRCC_LOAD_CYCLES;
          pulse_next = 1'b1;
        end
      end
      VCRCC_LOAD_BUSY: begin
        if (cnt_reg == 4'h1) begin
          state_next = VCRCC_LOAD_IDLE;
          stat_next = 1'b0;
        end
        cnt_next = cnt_reg - 4'h1;
      end
      default: state_next = VCRCC_LOAD_IDLE;
    endcase
    // A table write in the finishing cycle keeps the flag set
    if (table_write) begin
      stat_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= VCRCC_LOAD_IDLE;
      cnt_reg <= 4'h0;
      stat_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      stat_reg <= stat_next;
      pulse_reg <= pulse_next;
    end
  end

  assign load_pulse = pulse_reg;
  assign arb_table_status = stat_reg;
endmodule

//--- verilog/vcrcc_read_mux.sv
`timescale 1ns/1ps
`include "vcrcc_consts.svh"
module vcrcc_read_mux (
  input wire vcrcc_pkg::vcrcc_addr_t addr,
  input wire vcrcc_pkg::vcrcc_word_t cap_word,
  input wire vcrcc_pkg::vcrcc_word_t ctl_word,
  output vcrcc_pkg::vcrcc_word_t rd_word
);
  import vcrcc_pkg::*;
  always_comb begin
    case (addr)
      `VCRCC_CAP_OFFSET: rd_word = cap_word;
      `VCRCC_CTL_OFFSET: rd_word = ctl_word;
      // Unmapped addresses read as zero
      default: rd_word = 32'h00000000;
    endcase
  end
endmodule

//--- verilog/vcrcc_regs.sv
`timescale 1ns/1ps
`include "vcrcc_consts.svh"
// Contract
// - Arbitration capability resets to 0x1; only bit 0 may be set.
// - Table offset in bits 31:24, 16-byte units, resets to zero.
// - Advanced packet switch bit 14 and reject snoop bit 15 read zero.
// - Max time slots bits 22:16 read as zero.
// - Traffic class map resets to 0xFF, bit 0 fixed, bits 1-7 writable.
// - Writing one to load bit 16 loads the table; zero does nothing.
// - The load bit always reads zero.
// - A load is honoured only when the chosen scheme uses the table.
// - Channel identifier bits 26:24 are fixed zero.
// - Channel enable bit 31 is fixed one.
// - Table status sets on a table write, clears when a load finishes.
module vcrcc_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire vcrcc_pkg::vcrcc_addr_t addr,
  input wire vcrcc_pkg::vcrcc_word_t wdata,
  input wire logic wr,
  input wire logic rd,
  output vcrcc_pkg::vcrcc_word_t rdata,
  input wire logic write_lock_open,
  input wire logic table_entry_write,
  output logic [7:0] traffic_class_map,
  output logic [2:0] port_arb_select,
  output logic [7:0] port_arb_capability,
  output logic [7:0] arb_table_offset,
  output logic load_arb_table,
  output logic arb_table_status
);
  import vcrcc_pkg::*;

  ////////////////////////////////////////////////////////////
  logic [7:0] arbcap_reg, arbcap_next;
  logic [7:0] tbloff_reg, tbloff_next;
  logic [7:0] tcmap_reg, tcmap_next;
  logic [2:0] sel_reg, sel_next;
  vcrcc_word_t rdata_reg, rdata_next;
  vcrcc_word_t cap_word, ctl_word, rd_word;
  logic cap_wr, ctl_wr, load_req, table_used;

  assign cap_wr = wr && (addr == `VCRCC_CAP_OFFSET);
  assign ctl_wr = wr && (addr == `VCRCC_CTL_OFFSET);

  // Only hardware fixed round robin exists, and its scheme number
  // is zero; a table-based scheme would have a higher number whose
  // capability bit is never set, so no request ever reaches the loader.
  assign table_used = (sel_reg != 3'h0) && arbcap_reg[sel_reg];
  assign load_req = ctl_wr && wdata[`VCRCC_LOAD_BIT] && table_used;

  always_comb begin
    arbcap_next = arbcap_reg;
    tbloff_next = tbloff_reg;
    tcmap_next = tcmap_reg;
    sel_next = sel_reg;
    if (cap_wr && write_lock_open) begin
      arbcap_next = wdata[`VCRCC_ARBCAP_MSB:`VCRCC_ARBCAP_LSB]
        & `VCRCC_ARBCAP_MASK;
      tbloff_next = wdata[`VCRCC_TBLOFF_MSB:`VCRCC_TBLOFF_LSB];
    end
    if (ctl_wr) begin
      tcmap_next = (wdata[`VCRCC_TCMAP_MSB:`VCRCC_TCMAP_LSB]
        & `VCRCC_TCMAP_WMASK) | ~`VCRCC_TCMAP_WMASK;
      // Software keeps this to a supported scheme
      sel_next = wdata[`VCRCC_SEL_MSB:`VCRCC_SEL_LSB];
    end
  end

  always_comb begin
    cap_word = 32'h00000000;
    cap_word[`VCRCC_ARBCAP_MSB:`VCRCC_ARBCAP_LSB] = arbcap_reg;
    cap_word[`VCRCC_APS_BIT] = 1'b0;
    cap_word[`VCRCC_REJECT_SNOOP_BIT] = 1'b0;
    cap_word[`VCRCC_MAX_TIME_SLOTS_MSB:`VCRCC_MAX_TIME_SLOTS_LSB] = 7'h00;
    cap_word[`VCRCC_TBLOFF_MSB:`VCRCC_TBLOFF_LSB] = tbloff_reg;
    ctl_word = 32'h00000000;
    ctl_word[`VCRCC_TCMAP_MSB:`VCRCC_TCMAP_LSB] = tcmap_reg;
    ctl_word[`VCRCC_LOAD_BIT] = 1'b0;
    ctl_word[`VCRCC_SEL_MSB:`VCRCC_SEL_LSB] = sel_reg;
    ctl_word[`VCRCC_CHANNEL_IDENTIFIER_MSB:`VCRCC_CHANNEL_IDENTIFIER_LSB] = `VCRCC_CHANNEL_IDENTIFIER_VALUE;
    ctl_word[`VCRCC_CHANNEL_ENABLE_BIT] = 1'b1;
    rdata_next = rd ? rd_word : 32'h00000000;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arbcap_reg <= `VCRCC_ARBCAP_RESET;
      tbloff_reg <= `VCRCC_TBLOFF_RESET;
      tcmap_reg <= `VCRCC_TCMAP_RESET;
      sel_reg <= `VCRCC_SEL_RESET;
      rdata_reg <= 32'h00000000;
    end else begin
      arbcap_reg <= arbcap_next;
      tbloff_reg <= tbloff_next;
      tcmap_reg <= tcmap_next;
      sel_reg <= sel_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////
  vcrcc_read_mux u_mux (
    .addr(addr),
    .cap_word(cap_word),
    .ctl_word(ctl_word),
    .rd_word(rd_word)
  );

  vcrcc_table_loader u_loader (
    .clk(clk),
    .resetn(resetn),
    .load_req(load_req),
    .table_write(table_entry_write),
    .load_pulse(load_arb_table),
    .arb_table_status(arb_table_status)
  );

  assign rdata = rdata_reg;
  assign traffic_class_map = tcmap_reg;
  assign port_arb_select = sel_reg;
  assign port_arb_capability = arbcap_reg;
  assign arb_table_offset = tbloff_reg;
endmodule

//--- bench/vcrcc_regs_properties.sv
`timescale 1ns/1ps
module vcrcc_regs_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire vcrcc_pkg::vcrcc_addr_t addr,
  input wire vcrcc_pkg::vcrcc_word_t wdata,
  input wire logic wr,
  input wire logic rd,
  input wire vcrcc_pkg::vcrcc_word_t rdata,
  input wire logic write_lock_open,
  input wire logic table_entry_write,
  input wire logic [7:0] traffic_class_map,
  input wire logic [2:0] port_arb_select,
  input wire logic [7:0] port_arb_capability,
  input wire logic [7:0] arb_table_offset,
  input wire logic load_arb_table,
  input wire logic arb_table_status
);
  import vcrcc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_ctl_wr;
    wr && addr == 12'h114;
  endsequence
  sequence s_cap_rd;
    rd && addr == 12'h110;
  endsequence
  a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not zero when idle");
  a_cap_fixed: assert property (s_cap_rd |=> rdata[23:8] == 16'h0)
    else $error("fixed capability bits not zero");
  a_ctl_fixed: assert property (rd && addr == 12'h114 |=>
    rdata[31:20] == 12'h800 && rdata[16:8] == 9'h0)
    else $error("fixed control bits wrong");
  a_tc_write: assert property (s_ctl_wr |=>
    traffic_class_map == {$past(wdata[7:1]), 1'b1})
    else $error("class map write wrong");
  a_cap_mask: assert property (port_arb_capability[7:1] == 7'h0)
    else $error("unsupported scheme advertised");
  a_cap_locked: assert property (wr && !write_lock_open |=>
    $stable(port_arb_capability) && $stable(arb_table_offset))
    else $error("locked field changed");
  a_load_zero: assert property (s_ctl_wr ##0 !wdata[16] |=>
    !load_arb_table)
    else $error("load without request");
  a_status_set: assert property (table_entry_write |=> arb_table_status)
    else $error("status not set");
endmodule
bind vcrcc_regs vcrcc_regs_chk chk_u (.clk(clk), .resetn(resetn),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .write_lock_open(write_lock_open), .table_entry_write(table_entry_write),
  .traffic_class_map(traffic_class_map), .port_arb_select(port_arb_select),
  .port_arb_capability(port_arb_capability),
  .arb_table_offset(arb_table_offset), .load_arb_table(load_arb_table),
  .arb_table_status(arb_table_status));

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import vcrcc_pkg::*;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, lock = 0, tew = 0, load, sts;
  vcrcc_addr_t addr = 12'h0;
  vcrcc_word_t wdata = 32'h0, rdata;
  logic [7:0] tcm, cap, toff;
  logic [2:0] sel;
  int n_errors = 0, checks = 0;
  vcrcc_regs dut_u (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .write_lock_open(lock),
    .table_entry_write(tew), .traffic_class_map(tcm), .port_arb_select(sel),
    .port_arb_capability(cap), .arb_table_offset(toff),
    .load_arb_table(load), .arb_table_status(sts));
  initial begin
    forever #10 clk = ~clk;
  end
  task chk(input vcrcc_word_t got, input vcrcc_word_t exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobes drop right after the sampling edge; #1 lets outputs settle
  task bus_wr(input vcrcc_addr_t a, input vcrcc_word_t d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task bus_rd(input vcrcc_addr_t a, input vcrcc_word_t exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task t_reset;
    chk(cap, 8'h01);
    chk(tcm, 8'hFF);
    bus_rd(12'h114, 32'h8000_00FF);
    bus_wr(12'h118, 32'hFFFF_FFFF);
    bus_rd(12'h118, 32'h0);
    $display("reset test done");
  endtask
  task t_ctl;
    bus_wr(12'h114, 32'hFFF1_FF00);
    chk(tcm, 8'h01);
    chk(load, 1'b0);
    chk(sel, 3'h0);
    bus_rd(12'h114, 32'h8000_0001);
    $display("control test done");
  endtask
  task t_cap;
    bus_wr(12'h110, 32'hFFFF_FFFE);
    bus_rd(12'h110, 32'h0000_0001);
    @(posedge clk);
    lock <= 1'b1;
    bus_wr(12'h110, 32'hABFF_FFFF);
    chk(toff, 8'hAB);
    bus_rd(12'h110, 32'hAB00_0001);
    $display("capability test done");
  endtask
  task t_status;
    chk(sts, 1'b0);
    @(posedge clk);
    tew <= 1'b1;
    @(posedge clk);
    tew <= 1'b0;
    #1 chk(sts, 1'b1);
    // Scheme 0 uses no table, so the load is dropped
    bus_wr(12'h114, 32'h0001_0000);
    repeat (6) @(posedge clk);
    #1 chk(sts, 1'b1);
    $display("status test done");
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_ctl();
    t_cap();
    t_status();
    final_report();
  end
endmodule
